/* File: rec_pkg.sv */
// package for the regulator enable control block
// assumes a single 40 MHz clock domain and an APB register port
package rec_pkg;

  localparam logic [15:0] REC_RTC_PM_OFFSET    = 16'h1930;
  localparam logic [15:0] REC_REG_CTRL_OFFSET  = 16'h7004;
  localparam int          REC_PM_CLKOUT_BIT    = 0;
  localparam int          REC_PM_REGPD_BIT     = 1;
  localparam int          REC_PM_BGPD_BIT      = 2;
  localparam int          REC_PM_WDIR_BIT      = 3;
  localparam int          REC_PM_WOUT_BIT      = 4;
  localparam int          REC_RC_USBEN_BIT     = 0;
  localparam int          REC_RC_VSEL_BIT      = 1;
  localparam logic [4:0]  REC_PM_RESET         = 5'h10;
  localparam logic [1:0]  REC_RC_RESET         = 2'h0;
  localparam logic [6:0]  REC_OUT_RESET        = 7'h64;

  typedef struct packed {
    logic       wake_pin_output;
    logic       wake_pin_direction;
    logic       bandgap_powerdown;
    logic       regulator_powerdown;
    logic       clkout_en;
  } rec_pm_s;

  typedef struct packed {
    logic       core_regulator_voltage_select;
    logic       usb_regulator_enable;
  } rec_rc_s;

  typedef struct packed {
    logic       analog_on;
    logic       core_on;
    logic       usb_on;
    logic       core_low_voltage;
    logic       bandgap_on;
    logic       wake_drive_low;
    logic       clkout_en;
  } rec_out_s;

  typedef struct packed {
    rec_pm_s     pm;
    rec_rc_s     rc;
    rec_out_s    out;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rec_state_s;

endpackage : rec_pkg

/* File: rec_regulator_enable_control.sv */
// regulator enable control: decodes regulator on/off state and core voltage
// assumes synchronous inputs, APB master on mclk, rst asynchronous active high
// Summary of operation
// R1: voltage select bit 1: clear gives 1.3 V core, set gives 1.05 V.
// R2: usb enable bit 0: clear turns usb regulator off and floats output.
// R3: control register bits 15:2 read zero and ignore writes.
// R4: after reset usb enable and voltage select are zero.
// R5: either power-down bit turns all regulators off.
// R6: no power-down: analog on, core on while pin low, usb on while enabled.
// R7: after power-down only a wake pin, rtc alarm or power cycle restores; the code also restores on an APB write to 1930h.
// R8: analog regulator is switched only by the power-down bits.
// R9: software on slow parts selects 1.05 V after reset.
// R10: regulator control register is 16 bits at 7004h.
// R11: rtc power management register is 16 bits at 1930h, bits 4:0.
// R12: regulator power-down keeps bandgap on; bandgap power-down turns it off.
// R13: software sets wake pin as input before power-down.
// R14: wake pin as input is active high.
// R15: a qualifying wake clears both power-down bits.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module rec_regulator_enable_control (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [15:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  input  wire logic                core_regulator_enable_pin,
  input  wire logic                wake_pin_in,
  input  wire logic                rtc_alarm,
  output logic                     analog_regulator_on,
  output logic                     core_regulator_on,
  output logic                     usb_regulator_on,
  output logic                     core_regulator_low_voltage,
  output logic                     bandgap_on,
  output logic                     wake_pin_oe,
  output logic                     wake_pin_out,
  output logic                     rtc_clock_out_enable
);
  import rec_pkg::*;

  rec_state_s state_reg;
  rec_state_s state_next;
  logic       wake_event;
  logic       setup;
  logic       wr;
  logic       hit_pm;
  logic       hit_rc;
  logic       pd_any;

  always_comb begin
    state_next = state_reg;
    setup      = psel && !penable;
    wr         = psel && penable && pwrite && state_reg.pready;
    hit_pm     = (paddr == REC_RTC_PM_OFFSET);  // [R11]
    hit_rc     = (paddr == REC_REG_CTRL_OFFSET);  // [R10]
    // wake input only counts while configured as active-high input
    wake_event = (wake_pin_in && !state_reg.pm.wake_pin_direction) || rtc_alarm;  // [R14] [R7]
    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;
    state_next.prdata  = 32'h0000_0000;
    if (setup) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !(hit_pm || hit_rc);
      if (!pwrite && hit_pm) begin
        state_next.prdata = {27'h0000000, state_reg.pm.wake_pin_output,
                             state_reg.pm.wake_pin_direction,
                             state_reg.pm.bandgap_powerdown,
                             state_reg.pm.regulator_powerdown,
                             state_reg.pm.clkout_en};
      end else if (!pwrite && hit_rc) begin
        state_next.prdata = {30'h00000000,
                             state_reg.rc.core_regulator_voltage_select,
                             state_reg.rc.usb_regulator_enable};  // [R3]
      end
    end
    if (wr && pstrb[0] && hit_pm) begin
      state_next.pm.clkout_en           = pwdata[REC_PM_CLKOUT_BIT];
      state_next.pm.regulator_powerdown = pwdata[REC_PM_REGPD_BIT];
      state_next.pm.bandgap_powerdown   = pwdata[REC_PM_BGPD_BIT];
      state_next.pm.wake_pin_direction  = pwdata[REC_PM_WDIR_BIT];
      state_next.pm.wake_pin_output     = pwdata[REC_PM_WOUT_BIT];
    end
    if (wr && pstrb[0] && hit_rc) begin
      // only bits 1:0 are stored
      state_next.rc.usb_regulator_enable          = pwdata[REC_RC_USBEN_BIT];  // [R2] [R3]
      state_next.rc.core_regulator_voltage_select = pwdata[REC_RC_VSEL_BIT];  // [R1]
    end
    // wake clears power-down; a wake wins over a same-cycle write
    if (wake_event) begin
      state_next.pm.regulator_powerdown = 1'b0;  // [R15] [R7]
      state_next.pm.bandgap_powerdown   = 1'b0;  // [R15]
    end
    pd_any = state_next.pm.regulator_powerdown || state_next.pm.bandgap_powerdown;
    state_next.out.analog_on        = !pd_any;  // [R5] [R8]
    state_next.out.core_on          = !pd_any && !core_regulator_enable_pin;  // [R6]
    state_next.out.usb_on           = !pd_any && state_next.rc.usb_regulator_enable;  // [R6] [R2]
    state_next.out.core_low_voltage = state_next.rc.core_regulator_voltage_select;  // [R1]
    state_next.out.bandgap_on       = !state_next.pm.bandgap_powerdown;  // [R12]
    state_next.out.wake_drive_low   = state_next.pm.wake_pin_direction &&
                                      !state_next.pm.wake_pin_output;
    state_next.out.clkout_en        = state_next.pm.clkout_en;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg.pm      <= rec_pm_s'(REC_PM_RESET);
      state_reg.rc      <= rec_rc_s'(REC_RC_RESET);  // [R4]
      state_reg.out     <= rec_out_s'(REC_OUT_RESET);  // [R4]
      state_reg.pready  <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign pready                     = state_reg.pready;
  assign pslverr                    = state_reg.pslverr;
  assign prdata                     = state_reg.prdata;
  assign analog_regulator_on        = state_reg.out.analog_on;
  assign core_regulator_on          = state_reg.out.core_on;
  assign usb_regulator_on           = state_reg.out.usb_on;
  assign core_regulator_low_voltage = state_reg.out.core_low_voltage;
  assign bandgap_on                 = state_reg.out.bandgap_on;
  assign wake_pin_oe                = state_reg.out.wake_drive_low;
  assign wake_pin_out               = 1'b0;
  assign rtc_clock_out_enable       = state_reg.out.clkout_en;

  // assertions
  pd_off_a: assert property (@(posedge mclk) disable iff (rst)  // [R5]
    (clk_en && $past(clk_en) && (state_reg.pm.regulator_powerdown || state_reg.pm.bandgap_powerdown))
      |-> !analog_regulator_on && !core_regulator_on && !usb_regulator_on)
    else $error("regulator on during power-down");
  core_pin_a: assert property (@(posedge mclk) disable iff (rst)  // [R6]
    (clk_en && $past(clk_en) && core_regulator_on) |-> !$past(core_regulator_enable_pin))
    else $error("core regulator on with pin high");
  usb_en_a: assert property (@(posedge mclk) disable iff (rst)  // [R2]
    usb_regulator_on |-> state_reg.rc.usb_regulator_enable)
    else $error("usb regulator on while disabled");
  analog_only_a: assert property (@(posedge mclk) disable iff (rst)  // [R8]
    !analog_regulator_on |-> (state_reg.pm.regulator_powerdown || state_reg.pm.bandgap_powerdown))
    else $error("analog regulator off without power-down");
  bandgap_keep_a: assert property (@(posedge mclk) disable iff (rst)  // [R12]
    (state_reg.pm.regulator_powerdown && !state_reg.pm.bandgap_powerdown) |-> bandgap_on)
    else $error("bandgap off under regulator power-down");
  wake_clear_a: assert property (@(posedge mclk) disable iff (rst)  // [R15]
    (clk_en && rtc_alarm) |=> !state_reg.pm.regulator_powerdown && !state_reg.pm.bandgap_powerdown)
    else $error("wake did not clear power-down");
  stay_down_a: assert property (@(posedge mclk) disable iff (rst)  // [R7]
    (state_reg.pm.bandgap_powerdown && !wake_event && !(wr && hit_pm)) |=>
      state_reg.pm.bandgap_powerdown)
    else $error("power-down left without wake");
  rsvd_zero_a: assert property (@(posedge mclk) disable iff (rst)  // [R3]
    pready |-> prdata[31:5] == 27'h0000000)
    else $error("reserved read bits nonzero");
  vsel_map_a: assert property (@(posedge mclk) disable iff (rst)  // [R1]
    (clk_en && $past(clk_en)) |-> core_regulator_low_voltage ==
      state_reg.rc.core_regulator_voltage_select)
    else $error("voltage select mismatch");

  // apb phases
  sequence setup_seq;
    clk_en && psel && !penable;
  endsequence

  sequence access_seq;
    clk_en && psel && penable;
  endsequence

  apb_txn_a: assert property (@(posedge mclk) disable iff (rst)  // [R10]
    setup_seq ##1 access_seq
      |-> pready)
    else $error("no ready in access phase");

  ready_pulse_a: assert property (@(posedge mclk) disable iff (rst)  // [R10]
    (clk_en && pready)
      |=> !pready)
    else $error("ready held too long");

  ready_follow_a: assert property (@(posedge mclk) disable iff (rst)  // [R10]
    (clk_en && psel && !penable)
      |=> pready)
    else $error("ready missing after setup");

  err_pair_a: assert property (@(posedge mclk) disable iff (rst)  // [R10]
    pslverr
      |-> pready)
    else $error("error without ready");

  err_unmapped_a: assert property (@(posedge mclk) disable iff (rst)  // [R10] [R11]
    (clk_en && psel && !penable && !(paddr == REC_RTC_PM_OFFSET || paddr == REC_REG_CTRL_OFFSET))
      |=> pslverr)
    else $error("unmapped address without error");

  err_mapped_a: assert property (@(posedge mclk) disable iff (rst)  // [R11]
    (clk_en && psel && !penable && (paddr == REC_RTC_PM_OFFSET || paddr == REC_REG_CTRL_OFFSET))
      |=> !pslverr)
    else $error("mapped address with error");

  rc_read_zero_a: assert property (@(posedge mclk) disable iff (rst)  // [R3]
    (clk_en && psel && !penable && !pwrite && paddr == REC_REG_CTRL_OFFSET)
      |=> prdata[31:2] == 30'h00000000)
    else $error("control read upper bits nonzero");

  rc_read_val_a: assert property (@(posedge mclk) disable iff (rst)  // [R4]
    (clk_en && psel && !penable && !pwrite && paddr == REC_REG_CTRL_OFFSET)
      |=> prdata[1:0] == $past(state_reg.rc))
    else $error("control read value wrong");

  pm_read_val_a: assert property (@(posedge mclk) disable iff (rst)  // [R11]
    (clk_en && psel && !penable && !pwrite && paddr == REC_RTC_PM_OFFSET)
      |=> prdata[4:0] == $past(state_reg.pm))
    else $error("power management read value wrong");

  pm_read_zero_a: assert property (@(posedge mclk) disable iff (rst)  // [R11]
    (clk_en && psel && !penable && !pwrite && paddr == REC_RTC_PM_OFFSET)
      |=> prdata[31:5] == 27'h0000000)
    else $error("power management upper bits nonzero");

  idle_zero_a: assert property (@(posedge mclk) disable iff (rst)  // [R3]
    (clk_en && !(psel && !penable))
      |=> prdata == 32'h00000000 && !pready)
    else $error("read data outside read");

  write_data_a: assert property (@(posedge mclk) disable iff (rst)  // [R3]
    (clk_en && psel && !penable && pwrite)
      |=> prdata == 32'h00000000)
    else $error("read data on write");

  rc_write_a: assert property (@(posedge mclk) disable iff (rst)  // [R2] [R1]
    (clk_en && wr && pstrb[0] && hit_rc)
      |=> state_reg.rc == $past(pwdata[1:0]))
    else $error("control write not stored");

  rc_hold_a: assert property (@(posedge mclk) disable iff (rst)  // [R2]
    !(clk_en && wr && pstrb[0] && hit_rc)
      |=> $stable(state_reg.rc))
    else $error("control register changed");

  pm_write_a: assert property (@(posedge mclk) disable iff (rst)  // [R11]
    (clk_en && wr && pstrb[0] && hit_pm && !wake_event)
      |=> state_reg.pm == $past(pwdata[4:0]))
    else $error("power management write not stored");

  strobe_off_a: assert property (@(posedge mclk) disable iff (rst)  // [R3]
    (wr && !pstrb[0])
      |=> $stable(state_reg.rc))
    else $error("write without strobe stored");

  unmapped_wr_a: assert property (@(posedge mclk) disable iff (rst)  // [R10]
    (wr && !hit_pm && !hit_rc)
      |=> $stable(state_reg.rc))
    else $error("unmapped write stored");

  freeze_a: assert property (@(posedge mclk) disable iff (rst)
    !clk_en
      |=> $stable(state_reg))
    else $error("state moved while frozen");

  core_off_pin_a: assert property (@(posedge mclk) disable iff (rst)  // [R6]
    (clk_en && core_regulator_enable_pin)
      |=> !core_regulator_on)
    else $error("core regulator on with pin high");

  core_on_pin_a: assert property (@(posedge mclk) disable iff (rst)  // [R6]
    (clk_en && !core_regulator_enable_pin)
      |=> core_regulator_on == analog_regulator_on)
    else $error("core regulator off with pin low");

  usb_follow_a: assert property (@(posedge mclk) disable iff (rst)  // [R2] [R6]
    clk_en
      |=> usb_regulator_on == (analog_regulator_on && state_reg.rc.usb_regulator_enable))
    else $error("usb regulator state wrong");

  analog_pd_a: assert property (@(posedge mclk) disable iff (rst)  // [R5] [R8]
    clk_en
      |=> analog_regulator_on ==
        !(state_reg.pm.regulator_powerdown || state_reg.pm.bandgap_powerdown))
    else $error("analog regulator state wrong");

  bandgap_pd_a: assert property (@(posedge mclk) disable iff (rst)  // [R12]
    clk_en
      |=> bandgap_on == !state_reg.pm.bandgap_powerdown)
    else $error("bandgap state wrong");

  lowv_write_a: assert property (@(posedge mclk) disable iff (rst)  // [R1]
    (clk_en && wr && pstrb[0] && hit_rc)
      |=> core_regulator_low_voltage == $past(pwdata[1]))
    else $error("voltage select not applied");

  usb_write_off_a: assert property (@(posedge mclk) disable iff (rst)  // [R2]
    (clk_en && wr && pstrb[0] && hit_rc && !pwdata[0])
      |=> !usb_regulator_on)
    else $error("usb regulator on after disable");

  reg_pd_off_a: assert property (@(posedge mclk) disable iff (rst)  // [R5]
    (clk_en && wr && pstrb[0] && hit_pm && pwdata[1] && !wake_event)
      |=> !analog_regulator_on && !core_regulator_on && !usb_regulator_on)
    else $error("regulator power-down ignored");

  bandgap_powerdown_off_a: assert property (@(posedge mclk) disable iff (rst)  // [R5] [R12]
    (clk_en && wr && pstrb[0] && hit_pm && pwdata[2] && !wake_event)
      |=> !analog_regulator_on && !bandgap_on)
    else $error("bandgap power-down ignored");

  reg_pd_bg_a: assert property (@(posedge mclk) disable iff (rst)  // [R12]
    (clk_en && wr && pstrb[0] && hit_pm && pwdata[1] && !pwdata[2] && !wake_event)
      |=> bandgap_on)
    else $error("bandgap lost under regulator power-down");

  wake_pin_clear_a: assert property (@(posedge mclk) disable iff (rst)  // [R14] [R15]
    (clk_en && wake_pin_in && !state_reg.pm.wake_pin_direction)
      |=> !state_reg.pm.regulator_powerdown && !state_reg.pm.bandgap_powerdown)
    else $error("wake pin did not clear power-down");

  wake_beats_wr_a: assert property (@(posedge mclk) disable iff (rst)  // [R15]
    (clk_en && wake_event && wr && hit_pm)
      |=> !state_reg.pm.regulator_powerdown && !state_reg.pm.bandgap_powerdown)
    else $error("write beat a wake");

  reg_stay_down_a: assert property (@(posedge mclk) disable iff (rst)  // [R7]
    (state_reg.pm.regulator_powerdown && !wake_event && !(wr && hit_pm))
      |=> state_reg.pm.regulator_powerdown)
    else $error("regulator power-down left without wake");

  wake_dir_out_a: assert property (@(posedge mclk) disable iff (rst)  // [R7] [R14]
    (state_reg.pm.wake_pin_direction && state_reg.pm.regulator_powerdown && !rtc_alarm &&
     !(wr && hit_pm))
      |=> state_reg.pm.regulator_powerdown)
    else $error("output wake pin restored regulators");

  wake_drive_a: assert property (@(posedge mclk) disable iff (rst)  // [R11]
    clk_en
      |=> wake_pin_oe == (state_reg.pm.wake_pin_direction && !state_reg.pm.wake_pin_output))
    else $error("wake pin drive wrong");

  clkout_a: assert property (@(posedge mclk) disable iff (rst)  // [R11]
    clk_en
      |=> rtc_clock_out_enable == state_reg.pm.clkout_en)
    else $error("clock output enable wrong");

endmodule : rec_regulator_enable_control

/* File: tb_top.sv */
// testbench for the regulator enable control block
// assumes the design answers apb in one access cycle
`timescale 1ns/1ps
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin fails++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_top;
  import rec_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, pin, wake, alarm;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic        e;
  logic [6:0]  o;
  int          fails, tests_run, seed;
  rec_regulator_enable_control dut (.mclk(mclk), .rst(rst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .core_regulator_enable_pin(pin),
    .wake_pin_in(wake), .rtc_alarm(alarm), .analog_regulator_on(o[6]),
    .core_regulator_on(o[5]), .usb_regulator_on(o[4]), .core_regulator_low_voltage(o[3]),
    .bandgap_on(o[2]), .wake_pin_oe(o[1]), .wake_pin_out(), .rtc_clock_out_enable(o[0]));
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  function logic [2:0] exp_on(input logic pd, input logic usb, input logic p);
    return pd ? 3'h0 : {1'b1, ~p, usb};
  endfunction : exp_on
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk iff (pready === 1'b1));
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  task pulse(input logic al);
    @(posedge mclk);
    if (al) alarm <= 1; else wake <= 1;
    @(posedge mclk);
    alarm <= 0; wake <= 0;
    settle;
  endtask : pulse
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    report_and_stop;
  end
  initial begin
    seed = 2;
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pin = 0; wake = 0; alarm = 0;
    repeat (5) @(posedge mclk);
    rst <= 0;
    settle;
    `CHK(o[6:3], 4'hC)
    apb(0, 16'h7004, 0);
    `CHK(r, 32'h0)
    apb(0, 16'h1930, 0);
    `CHK(r, 32'h10)
    apb(0, 16'h0100, 0);
    `CHK(e, 1'b1)
    $display("test reset done");
    repeat (10) begin
      v = $random(seed);
      pin <= v[2];
      apb(1, 16'h7004, v);
      apb(0, 16'h7004, 0);
      `CHK(r, {30'h0, v[1:0]})
      settle;
      `CHK(o[6:4], exp_on(0, v[0], v[2]))
      `CHK(o[3], v[1])
    end
    $display("test decode done");
    pin <= 0;
    apb(1, 16'h7004, 32'hFFFF);
    apb(1, 16'h1930, 32'h9);
    settle;
    `CHK(o[1:0], 2'h3)
    for (int i = 0; i < 2; i++) begin
      apb(1, 16'h1930, 32'h12 << i);
      settle;
      `CHK(o[6:4], 3'h0)
      `CHK(o[2], i == 0)
      pulse(i);
      apb(0, 16'h1930, 0);
      `CHK(r, (i == 0) ? 32'h10 : 32'h0)
      `CHK(o[6:4], exp_on(0, 1, 0))
    end
    apb(1, 16'h1930, 32'h1A);
    pulse(0);
    `CHK(o[6:4], 3'h0)
    pulse(1);
    `CHK(o[6:2], 5'h1F)
    $display("test powerdown done");
    report_and_stop;
  end
endmodule : tb_top
